// ---- hdl/adc_ctrl_pkg.sv ----
// Purpose: shared constants and types of the converter control block
// Assumes: 32-bit AXI4-Lite register slave, 8-bit byte addresses
// Notes:   gain delays are counted in half working-clock periods
package adc_ctrl_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int        ADDR_W   = 8;
  localparam logic [7:0] OFF_CTL1 = 8'h00;
  localparam logic [7:0] OFF_CTL2 = 8'h04;
  localparam logic [7:0] OFF_INP  = 8'h08;
  localparam logic [7:0] OFF_TRIG = 8'h0C;
  localparam logic [7:0] OFF_IEN  = 8'h10;
  localparam logic [7:0] OFF_FLAG = 8'h14;
  localparam logic [7:0] OFF_RES  = 8'h18;
  localparam logic [7:0] OFF_DBG  = 8'h1C;
  localparam logic [7:0] OFF_TRIM = 8'h20;
  localparam logic [7:0] OFF_SAMP = 8'h24;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTL1_RST  = 0;
  localparam int CTL1_EN   = 1;
  localparam int CTL2_DIFF = 0;
  localparam int CTL2_FREE = 1;
  localparam int CTL2_EVT  = 2;
  localparam int CTL2_RES  = 4;
  localparam int CTL2_PRE  = 8;
  localparam int CTL2_OVS  = 12;
  localparam int INP_POS   = 0;
  localparam int INP_NEG   = 8;
  localparam int INP_GAIN  = 24;
  localparam int TRIG_GO   = 1;
  localparam int FLAG_RDY  = 0;
  localparam int FLAG_OVR  = 1;
  localparam int DBG_RUN   = 0;
  localparam int TRIM_W    = 11;
  localparam int SAMP_W    = 6;
  // ----------------------------------------------------------------
  // reset values and encodings
  // ----------------------------------------------------------------
  localparam logic [15:0] CTL2_RST_VAL = 16'h0000;
  localparam logic [31:0] INP_RST_VAL  = 32'h0000_0000;
  localparam logic [1:0]  RES_12       = 2'h0;
  localparam logic [1:0]  RES_10       = 2'h2;
  localparam logic [1:0]  RES_8        = 2'h3;
  localparam logic [2:0]  OVS_MAX      = 3'h4;
  localparam logic [1:0]  RESP_OK      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  localparam logic [3:0]  GAIN_HALF    = 4'hF;

  typedef struct packed {
    logic       diff;
    logic [3:0] gain;
    logic [4:0] neg;
    logic [4:0] pos;
  } analog_sel_t;

  // gain delay in half periods
  function automatic logic [2:0] gain_halves(input logic [3:0] g,
                                             input logic d,
                                             input logic fr);
    logic [2:0] h;
    h = 3'h0;
    if (fr) begin
      case (g)
        4'h0: h = d ? 3'h0 : 3'h0;
        4'h1: h = d ? 3'h0 : 3'h2;
        4'h2: h = 3'h2;
        4'h3: h = d ? 3'h2 : 3'h4;
        4'h4: h = 3'h4;
        4'hF: h = d ? 3'h0 : 3'h2;
        default: h = 3'h0;
      endcase
    end else begin
      case (g)
        4'h0, 4'h1, 4'h2, 4'h3, 4'h4: h = g[2:0] + (d ? 3'h0 : 3'h2);
        4'hF: h = d ? 3'h1 : 3'h3;
        default: h = 3'h0;
      endcase
    end
    return h;
  endfunction
endpackage

// ---- hdl/adc_conv_ctrl.sv ----
// Purpose: control logic of a 12-bit successive-approximation converter
// Assumes: conversion clock and event arrive as pins, sampled on aclk
// Notes:   analog front end delivers conv_data, held at end of conversion
//
// How it works
// - writes are refused while locked, except to the flag register.
// - debugger-originated writes pass regardless of the lock.
// - 12-bit results by default; 10-bit or 8-bit shorten conversion.
// - oversampling accumulates up to 16 samples, widening result to 16 bits.
// - enable bit one turns converter on, zero turns it off.
// - soft reset clears all registers but debug control, disables converter.
// - conversion starts on software start bit or enabled event.
// - free-running waits for first start, then restarts at each end.
// - each finished conversion, or with oversampling only the last of a set, overwrites the result register.
// - result arriving before previous read sets overrun flag.
// - ready flag rises together with the stored result.
// - writing one to enable-set bit enables source; zero does nothing.
// - prescaler divides the conversion clock into the working clock.
// - latency is 1+res/2+gain+samp/2 single-shot, res/2+gain free-running.
// - gain field codes 0..4 and F with their delays.
// - converter samples the source chosen in input control.
// - input select addresses twenty analog pins plus references.
// - differential select bit chooses differential conversions.
// - start waits for conversion clock; input sampled first half period.
// - free-running sets ready at every conversion end, or with oversampling at the last of each set.
`timescale 1ns/1ns
module adc_conv_ctrl
  import adc_ctrl_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              write_lock,
  input  wire logic              debug_access,
  input  wire logic              debug_halt,
  input  wire logic              generic_conv_clock,
  input  wire logic              start_event,
  input  wire logic [11:0]       conv_data,
  output logic                   sample_req,
  output analog_sel_t            analog_sel,
  output logic [TRIM_W-1:0]      trim_out,
  output logic                   irq_req
);
  typedef enum logic [1:0] {IDLE, RUN} conv_state_t;
  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic              aw_held_reg, aw_held_next, w_held_reg, w_held_next;
  logic [7:0]        waddr_reg, waddr_next;
  logic [31:0]       wbuf_reg, wbuf_next;
  logic [3:0]        wstb_reg, wstb_next;
  logic              bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0]        bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0]       rdata_reg, rdata_next;
  logic              en_reg, en_next, dbg_reg, dbg_next;
  logic [15:0]       ctl2_reg, ctl2_next;
  logic [31:0]       inp_reg, inp_next;
  logic [1:0]        ien_reg, ien_next, flag_reg, flag_next;
  logic [TRIM_W-1:0] trim_reg, trim_next;
  logic [SAMP_W-1:0] samp_reg, samp_next;
  logic              pend_reg, pend_next, unread_reg, unread_next;
  logic [15:0]       result_reg, result_next;
  logic              wr_do, wr_lock, wr_bad, rd_do, res_wr, trig_sw;
  logic              soft_rst;
  logic              awready_reg, wready_reg, arready_reg;
  logic [31:0]       wd, cur;
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] gsync_reg, esync_reg;
  logic       gstate_reg, gstate_next, estate_reg, estate_next;
  logic       gtick, etick;
  always_comb begin
    gstate_next = gstate_reg;
    estate_next = estate_reg;
    gtick = 1'b0;
    etick = 1'b0;
    if (gsync_reg[2] == gsync_reg[1] && gsync_reg[2] != gstate_reg) begin
      gstate_next = gsync_reg[2];
      gtick = gsync_reg[2];
    end
    if (esync_reg[2] == esync_reg[1] && esync_reg[2] != estate_reg) begin
      estate_next = esync_reg[2];
      etick = esync_reg[2];
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gsync_reg  <= 3'h0;
      esync_reg  <= 3'h0;
      gstate_reg <= 1'b0;
      estate_reg <= 1'b0;
    end else begin
      gsync_reg  <= {gsync_reg[1:0], generic_conv_clock};
      esync_reg  <= {esync_reg[1:0], start_event};
      gstate_reg <= gstate_next;
      estate_reg <= estate_next;
    end
  end
  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  always_comb begin
    case (waddr_reg)
      OFF_CTL1: cur = {30'h0, en_reg, 1'b0};
      OFF_CTL2: cur = {16'h0, ctl2_reg};
      OFF_INP:  cur = inp_reg;
      OFF_IEN:  cur = {30'h0, ien_reg};
      OFF_DBG:  cur = {31'h0, dbg_reg};
      OFF_TRIM: cur = {21'h0, trim_reg};
      OFF_SAMP: cur = {26'h0, samp_reg};
      default:  cur = 32'h0000_0000;
    endcase
    for (int i = 0; i < 4; i++) begin
      wd[i*8 +: 8] = wstb_reg[i] ? wbuf_reg[i*8 +: 8] : cur[i*8 +: 8];
    end
    wr_do = aw_held_reg && w_held_reg && !bvalid_reg;
    wr_bad = !(waddr_reg inside {OFF_CTL1, OFF_CTL2, OFF_INP, OFF_TRIG,
      OFF_IEN, OFF_FLAG, OFF_DBG, OFF_TRIM, OFF_SAMP});
    wr_lock = write_lock && !debug_access && waddr_reg != OFF_FLAG;
    soft_rst = wr_do && !wr_lock && waddr_reg == OFF_CTL1 && wd[CTL1_RST];
    rd_do = arvalid && arready_reg;
    trig_sw = wr_do && !wr_lock && waddr_reg == OFF_TRIG && wd[TRIG_GO];
  end

  always_comb begin
    aw_held_next = aw_held_reg;
    w_held_next  = w_held_reg;
    waddr_next   = waddr_reg;
    wbuf_next    = wbuf_reg;
    wstb_next    = wstb_reg;
    bvalid_next  = bvalid_reg && !bready;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg && !rready;
    rresp_next   = rresp_reg;
    rdata_next   = rdata_reg;
    en_next      = en_reg;
    dbg_next     = dbg_reg;
    ctl2_next    = ctl2_reg;
    inp_next     = inp_reg;
    ien_next     = ien_reg;
    trim_next    = trim_reg;
    samp_next    = samp_reg;
    if (awvalid && awready_reg) begin
      aw_held_next = 1'b1;
      waddr_next = awaddr;
    end
    if (wvalid && wready_reg) begin
      w_held_next = 1'b1;
      wbuf_next = wdata;
      wstb_next = wstrb;
    end
    if (wr_do) begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = (wr_bad || wr_lock) ? RESP_SLVERR : RESP_OK;
      if (!wr_bad && !wr_lock) begin
        case (waddr_reg)
          OFF_CTL1: en_next = wd[CTL1_EN];
          OFF_CTL2: ctl2_next = wd[15:0];
          OFF_INP:  inp_next = wd;
          OFF_IEN:  ien_next = ien_reg | wd[1:0];
          OFF_DBG:  dbg_next = wd[DBG_RUN];
          OFF_TRIM: trim_next = wd[TRIM_W-1:0];
          OFF_SAMP: samp_next = wd[SAMP_W-1:0];
          default: ;
        endcase
      end
    end
    if (soft_rst) begin
      en_next = 1'b0;
      ctl2_next = CTL2_RST_VAL;
      inp_next = INP_RST_VAL;
      ien_next = 2'h0;
      trim_next = '0;
      samp_next = '0;
    end
    if (rd_do) begin
      rvalid_next = 1'b1;
      rresp_next = RESP_OK;
      case (araddr)
        OFF_CTL1: rdata_next = {30'h0, en_reg, 1'b0};
        OFF_CTL2: rdata_next = {16'h0, ctl2_reg};
        OFF_INP:  rdata_next = inp_reg;
        OFF_TRIG: rdata_next = {30'h0, pend_reg, 1'b0};
        OFF_IEN:  rdata_next = {30'h0, ien_reg};
        OFF_FLAG: rdata_next = {30'h0, flag_reg};
        OFF_RES:  rdata_next = {16'h0, result_reg};
        OFF_DBG:  rdata_next = {31'h0, dbg_reg};
        OFF_TRIM: rdata_next = {21'h0, trim_reg};
        OFF_SAMP: rdata_next = {26'h0, samp_reg};
        default: begin
          rdata_next = 32'h0000_0000;
          rresp_next = RESP_SLVERR;
        end
      endcase
    end
  end
  // ----------------------------------------------------------------
  // conversion engine
  // ----------------------------------------------------------------
  conv_state_t state_reg, state_next;
  logic [9:0]  div_reg, div_next;
  logic [6:0]  elap_reg, elap_next, target_reg, target_next;
  logic [3:0]  nsamp_reg, nsamp_next;
  logic [15:0] acc_reg, acc_next;
  logic        samp_out_reg, samp_out_next, htick, done, last;
  logic [11:0] scaled;
  logic [9:0]  half_len;
  logic [6:0]  lat_ss, lat_fr;
  logic [2:0]  ovs;
  always_comb begin
    // half working period is 2<<prescale conversion ticks
    half_len = 10'h002 << ctl2_reg[CTL2_PRE +: 3];
    div_next = div_reg;
    htick = 1'b0;
    if (gtick && !(debug_halt && !dbg_reg)) begin
      div_next = div_reg + 10'h001;
      if (div_next >= half_len) begin
        div_next = 10'h000;
        htick = 1'b1;
      end
    end
    case (ctl2_reg[CTL2_RES +: 2])
      RES_10:  scaled = {2'h0, conv_data[11:2]};
      RES_8:   scaled = {4'h0, conv_data[11:4]};
      default: scaled = conv_data;
    endcase
    // latency in half periods (res/2 periods = res halves)
    case (ctl2_reg[CTL2_RES +: 2])
      RES_10:  lat_fr = 7'd10;
      RES_8:   lat_fr = 7'd8;
      default: lat_fr = 7'd12;
    endcase
    lat_ss = lat_fr + 7'd2 + {4'h0, gain_halves(inp_reg[INP_GAIN +: 4],
             ctl2_reg[CTL2_DIFF], 1'b0)} + {1'b0, samp_reg};
    lat_fr = lat_fr + {4'h0, gain_halves(inp_reg[INP_GAIN +: 4],
             ctl2_reg[CTL2_DIFF], 1'b1)};
    ovs = (ctl2_reg[CTL2_OVS +: 3] > OVS_MAX) ? OVS_MAX
                                              : ctl2_reg[CTL2_OVS +: 3];
    done = state_reg == RUN && htick && elap_reg + 7'd1 >= target_reg;
    last = nsamp_reg + 4'h1 == 4'(5'h01 << ovs);
    res_wr = done && last;
  end

  always_comb begin
    state_next = state_reg;
    elap_next = elap_reg;
    target_next = target_reg;
    nsamp_next = nsamp_reg;
    acc_next = acc_reg;
    pend_next = pend_reg;
    result_next = result_reg;
    flag_next = flag_reg;
    unread_next = unread_reg;
    samp_out_next = 1'b0;
    if (en_reg && (trig_sw || (etick && ctl2_reg[CTL2_EVT])))
      pend_next = 1'b1;
    case (state_reg)
      IDLE: begin
        // start taken on a working clock edge
        if (pend_reg && en_reg && htick) begin
          pend_next = 1'b0;
          state_next = RUN;
          elap_next = 7'h00;
          target_next = lat_ss;
          nsamp_next = 4'h0;
          acc_next = 16'h0000;
        end
      end
      RUN: begin
        if (htick)
          elap_next = elap_reg + 7'd1;
        if (done) begin
          acc_next = acc_reg + {4'h0, scaled};
          nsamp_next = nsamp_reg + 4'h1;
          elap_next = 7'h00;
          target_next = lat_fr;
          if (last) begin
            nsamp_next = 4'h0;
            acc_next = 16'h0000;
            if (!(ctl2_reg[CTL2_FREE] && en_reg))
              state_next = IDLE;
          end
        end
      end
      default: state_next = IDLE;
    endcase
    // input sampled during the first half period
    samp_out_next = state_next == RUN && elap_next == 7'h00;
    // writing one clears flags; set wins
    if (wr_do && waddr_reg == OFF_FLAG)
      flag_next = flag_reg & ~wd[1:0];
    if (rd_do && araddr == OFF_RES)
      unread_next = 1'b0;
    if (res_wr) begin
      result_next = acc_reg + {4'h0, scaled};
      flag_next[FLAG_RDY] = 1'b1;
      unread_next = 1'b1;
      if (unread_reg)
        flag_next[FLAG_OVR] = 1'b1;
    end
    if (!en_reg) begin
      state_next = IDLE;
      samp_out_next = 1'b0;
    end
    if (soft_rst) begin
      pend_next = 1'b0;
      flag_next = 2'h0;
      unread_next = 1'b0;
      result_next = 16'h0000;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      waddr_reg   <= 8'h00;
      wbuf_reg    <= 32'h0000_0000;
      wstb_reg    <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OK;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= RESP_OK;
      rdata_reg   <= 32'h0000_0000;
      en_reg      <= 1'b0;
      dbg_reg     <= 1'b0;
      ctl2_reg    <= CTL2_RST_VAL;
      inp_reg     <= INP_RST_VAL;
      ien_reg     <= 2'h0;
      trim_reg    <= '0;
      samp_reg    <= '0;
      state_reg   <= IDLE;
      div_reg     <= 10'h000;
      elap_reg    <= 7'h00;
      target_reg  <= 7'h00;
      nsamp_reg   <= 4'h0;
      acc_reg     <= 16'h0000;
      pend_reg    <= 1'b0;
      result_reg  <= 16'h0000;
      flag_reg    <= 2'h0;
      unread_reg  <= 1'b0;
      samp_out_reg <= 1'b0;
    end else begin
      aw_held_reg <= aw_held_next;
      w_held_reg  <= w_held_next;
      waddr_reg   <= waddr_next;
      wbuf_reg    <= wbuf_next;
      wstb_reg    <= wstb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      rvalid_reg  <= rvalid_next;
      rresp_reg   <= rresp_next;
      rdata_reg   <= rdata_next;
      en_reg      <= en_next;
      dbg_reg     <= dbg_next;
      ctl2_reg    <= ctl2_next;
      inp_reg     <= inp_next;
      ien_reg     <= ien_next;
      trim_reg    <= trim_next;
      samp_reg    <= samp_next;
      state_reg   <= state_next;
      div_reg     <= div_next;
      elap_reg    <= elap_next;
      target_reg  <= target_next;
      nsamp_reg   <= nsamp_next;
      acc_reg     <= acc_next;
      pend_reg    <= pend_next;
      result_reg  <= result_next;
      flag_reg    <= flag_next;
      unread_reg  <= unread_next;
      samp_out_reg <= samp_out_next;
    end
  end
  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic irq_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_reg     <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      arready_reg <= 1'b0;
    end else begin
      irq_reg     <= |(flag_next & ien_next);
      awready_reg <= !aw_held_next && !bvalid_next;
      wready_reg  <= !w_held_next && !bvalid_next;
      arready_reg <= !rvalid_next;
    end
  end
  assign awready = awready_reg;
  assign wready  = wready_reg;
  assign bvalid  = bvalid_reg;
  assign bresp   = bresp_reg;
  assign arready = arready_reg;
  assign rvalid  = rvalid_reg;
  assign rdata   = rdata_reg;
  assign rresp   = rresp_reg;
  assign sample_req = samp_out_reg;
  assign trim_out = trim_reg;
  assign irq_req = irq_reg;
  // source, gain and mode to the front end
  assign analog_sel = '{diff: ctl2_reg[CTL2_DIFF],
                        gain: inp_reg[INP_GAIN +: 4],
                        neg: inp_reg[INP_NEG +: 5],
                        pos: inp_reg[INP_POS +: 5]};
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire ok_wr = wr_do && !wr_lock && !wr_bad;
  lock_blocks_a: assert property (
    wr_do && wr_lock && waddr_reg == OFF_CTL2 |=> $stable(ctl2_reg)
    && bresp == RESP_SLVERR) else $error("locked write landed");
  debug_bypass_a: assert property (
    wr_do && write_lock && debug_access && waddr_reg == OFF_TRIM
    |=> trim_reg == $past(wd[TRIM_W-1:0]))
    else $error("debugger write blocked");
  enable_follow_a: assert property (
    ok_wr && waddr_reg == OFF_CTL1 |=> en_reg == $past(wd[CTL1_EN])
    || $past(soft_rst)) else $error("enable mismatch");
  soft_reset_a: assert property (
    soft_rst |=> !en_reg && ctl2_reg == CTL2_RST_VAL
    && dbg_reg == $past(dbg_reg)) else $error("soft reset wrong");
  ready_result_a: assert property (
    res_wr && !soft_rst |=> flag_reg[FLAG_RDY] && unread_reg
    && result_reg == $past(acc_reg) + {4'h0, $past(scaled)})
    else $error("result or ready missing");
  overrun_set_a: assert property (
    res_wr && unread_reg |=> flag_reg[FLAG_OVR]) else $error("no overrun");
  ien_set_a: assert property (
    ok_wr && waddr_reg == OFF_IEN |=> ien_reg ==
    ($past(ien_reg) | $past(wd[1:0])) || $past(soft_rst))
    else $error("enable-set wrong");
  trig_off_a: assert property (
    !en_reg && !pend_reg |=> !pend_reg) else $error("start while off");
  free_again_a: assert property (
    res_wr && ctl2_reg[CTL2_FREE] && en_reg && !soft_rst
    |=> state_reg == RUN && target_reg == $past(lat_fr))
    else $error("free run stalled");
  sample_first_a: assert property (
    $rose(state_reg == RUN) |-> sample_req) else $error("sample phase wrong");
  sample_phase_a: assert property (
    sample_req |-> state_reg == RUN && elap_reg == 7'h00)
    else $error("sample outside first half");
  free_done_c: cover property (res_wr && ctl2_reg[CTL2_FREE]);
  overrun_c: cover property (res_wr && unread_reg);
  locked_c: cover property (wr_do && wr_lock);
  event_c: cover property (etick && en_reg && ctl2_reg[CTL2_EVT]);
endmodule

// ---- sim/analog_side.sv ----
// Purpose: far side of the converter, conversion clock and front end
// Assumes: conversion clock runs free, slower than aclk
// Notes:   level is held steady by the bench between conversions
`timescale 1ns/1ns
module analog_side (
  input  wire logic [11:0] level,
  output logic             generic_conv_clock,
  output logic [11:0]      conv_data
);
  initial begin
    generic_conv_clock = 1'b0;
    forever #20 generic_conv_clock = ~generic_conv_clock;
  end
  assign conv_data = level;
endmodule

// ---- sim/adc_conversion_control_test.sv ----
// Purpose: self-checking bench of the converter control block
// Assumes: register reads checked in order through an expectation queue
// Notes:   masks select which response and data bits are compared
`timescale 1ns/1ns
module adc_conversion_control_test
  import adc_ctrl_pkg::*;
;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, sample_req, irq_req;
  logic write_lock, debug_access, gclk, ev, sp;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd, r;
  logic [1:0] bresp, rresp;
  logic [11:0] conv_data, level, d2;
  logic [10:0] trim_out;
  analog_sel_t analog_sel;
  logic [67:0] q[$];
  logic [67:0] e;
  logic [33:0] got;
  int mismatches, checked, ns;
  localparam logic [33:0] F = '1;
  localparam logic [33:0] R = {2'b11, 32'h0};
  // ----------------------------------------------------------------
  // design and far side
  // ----------------------------------------------------------------
  adc_conv_ctrl u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .write_lock(write_lock), .debug_access(debug_access),
    .debug_halt(1'b0), .generic_conv_clock(gclk), .start_event(ev),
    .conv_data(conv_data), .sample_req(sample_req),
    .analog_sel(analog_sel), .trim_out(trim_out), .irq_req(irq_req));
  analog_side u_far (.level(level), .generic_conv_clock(gclk),
    .conv_data(conv_data));
  always #4 aclk = ~aclk;
  // ----------------------------------------------------------------
  // checking
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [33:0] s,
                     input logic [33:0] x);
    checked++;
    if (s !== x) begin
      mismatches++;
      $display("ERROR %s exp %h got %h", nm, x, s);
    end
  endtask
  task automatic wrap_up;
    if (mismatches == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  always @(negedge aclk) begin
    ns += int'(sample_req && !sp);
    sp = sample_req;
    if ((bvalid && bready) || (rvalid && rready)) begin
      e = q.pop_front();
      got = (bvalid && bready) ? {bresp, 32'h0} : {rresp, rdata};
      chk("bus reply", got & e[67:34], e[33:0] & e[67:34]);
    end
  end
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [33:0] x,
                     input logic [33:0] m);
    int n;
    logic ta, tw, tr, dn;
    @(posedge aclk);
    q.push_back({m, x});
    if (w) begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end else begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
    end
    for (n = 0; n < 64; n++) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tr = arvalid && arready;
      dn = w ? bvalid : rvalid;
      rd = rdata;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tr) arvalid <= 1'b0;
      if (dn) break;
    end
    bready <= 1'b0;
    rready <= 1'b0;
    if (!dn) begin
      mismatches++;
      wrap_up();
    end
  endtask
  task automatic poll(input int b);
    int k;
    rd = '0;
    for (k = 0; k < 600 && rd[b] !== 1'b1; k++) bus(0, OFF_FLAG, 0, 0, 0);
    if (rd[b] !== 1'b1) begin
      mismatches++;
      wrap_up();
    end
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    #700000;
    mismatches++;
    wrap_up();
  end
  initial begin
    {aclk, aresetn, awvalid, wvalid, arvalid, bready, rready} = '0;
    {awaddr, araddr, wdata, write_lock, debug_access, rd, ev} = '0;
    r = 32'h2062_864a;
    level = r[11:0];
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
    bus(0, OFF_CTL2, 0, {RESP_OK, 32'h0}, F);
    bus(1, 8'h30, 0, {RESP_SLVERR, 32'h0}, R);
    write_lock <= 1'b1;
    bus(1, OFF_CTL2, 32'h0000_0002, {RESP_SLVERR, 32'h0}, R);
    bus(1, OFF_FLAG, 32'h0000_0003, {RESP_OK, 32'h0}, R);
    debug_access <= 1'b1;
    r = xs(r);
    bus(1, OFF_TRIM, r, {RESP_OK, 32'h0}, R);
    write_lock <= 1'b0;
    debug_access <= 1'b0;
    bus(0, OFF_TRIM, 0, {RESP_OK, 21'h0, r[10:0]}, F);
    chk("trim_out", {23'h0, trim_out}, {23'h0, r[10:0]});
    bus(1, OFF_IEN, 32'h0000_0003, 0, 0);
    bus(1, OFF_IEN, 32'h0000_0000, 0, 0);
    bus(0, OFF_IEN, 0, {RESP_OK, 32'h3}, F);
    bus(1, OFF_TRIG, 32'h0000_0002, 0, 0);
    repeat (60) bus(0, OFF_FLAG, 0, {RESP_OK, 32'h0}, F);
    bus(1, OFF_CTL2, 32'h0000_0030, 0, 0);
    bus(1, OFF_DBG, 32'h0000_0001, 0, 0);
    bus(1, OFF_CTL1, 32'h0000_0001, 0, 0);
    bus(0, OFF_CTL2, 0, {RESP_OK, 32'h0}, F);
    bus(0, OFF_DBG, 0, {RESP_OK, 32'h1}, F);
    bus(0, OFF_CTL1, 0, {RESP_OK, 32'h0}, F);
    bus(1, OFF_CTL1, 32'h0000_0002, 0, 0);
    bus(1, OFF_INP, r, 0, 0);
    chk("sel", {19'h0, analog_sel}, {20'h0, r[27:24], r[12:8], r[4:0]});
    bus(1, OFF_IEN, 32'h0000_0003, 0, 0);
    bus(1, OFF_TRIG, 32'h0000_0002, 0, 0);
    poll(0);
    chk("samples", 34'(ns), 34'h1);
    chk("irq_req", {33'h0, irq_req}, 34'h1);
    r = xs(r);
    d2 = r[11:0];
    level <= d2;
    bus(1, OFF_CTL2, 32'h0000_0004, 0, 0);
    ev <= 1'b1;
    repeat (8) @(posedge aclk);
    ev <= 1'b0;
    poll(1);
    chk("samples", 34'(ns), 34'h2);
    bus(0, OFF_FLAG, 0, {RESP_OK, 32'h3}, F);
    bus(1, OFF_FLAG, 32'h0000_0003, 0, 0);
    bus(0, OFF_FLAG, 0, {RESP_OK, 32'h0}, F);
    chk("irq_req", {33'h0, irq_req}, 34'h0);
    bus(0, OFF_RES, 0, {RESP_OK, 20'h0, d2}, F);
    bus(1, OFF_CTL2, 32'h0000_0002, 0, 0);
    bus(1, OFF_TRIG, 32'h0000_0002, 0, 0);
    poll(0);
    bus(1, OFF_FLAG, 32'h0000_0003, 0, 0);
    bus(0, OFF_FLAG, 0, {RESP_OK, 32'h0}, F);
    poll(0);
    wrap_up();
  end
endmodule
